// ===== bench/csc_mem_model.sv
`timescale 1ns/1ns
module csc_mem_model (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire csc_pkg::csc_mem_pins_t pins,
  output logic [15:0]                 cs_len,
  output logic [15:0]                 we_pos
);
  import csc_pkg::*;
  logic [15:0] run;
  logic        cs_q;
  logic        we_q;
  // Memory side view: select width and write release point, in pclk cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run    <= 16'h0;
      cs_len <= 16'h0;
      we_pos <= 16'h0;
      cs_q   <= 1'b1;
      we_q   <= 1'b1;
    end
    else
    begin
      cs_q <= pins.cs_n;
      we_q <= pins.we_n;
      if (!pins.cs_n)
        run <= run + 16'h1;
      if (pins.cs_n && !cs_q)
      begin
        cs_len <= run;
        run    <= 16'h0;
      end
      if (pins.we_n && !we_q)
        we_pos <= run;
    end
  end
endmodule // csc_mem_model

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp); \
    end \
  end
module tb_top;
  import csc_pkg::*;
  localparam logic [11:0] GCS = OFS_GLOBAL_CTRL_STATUS;
  localparam logic [11:0] PSC = OFS_PSAVE_CS_CTRL;
  localparam logic [11:0] IST = OFS_IRQ_STATUS;
  localparam logic [11:0] IMK = OFS_IRQ_MASK;
  logic           pclk = 1'b0;
  logic           presetn = 1'b0;
  csc_apb_req_t   apb_req = '0;
  logic           clk32_pin = 1'b0;
  logic           wdt_expire = 1'b0;
  logic           periodic_ack = 1'b0;
  csc_mem_req_t   mem_req = '0;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           mem_busy;
  logic           mem_done;
  csc_mem_pins_t  mem_pins;
  logic           cpu_clk_tick;
  logic           per_clk_tick;
  logic           osc_enable;
  logic           periodic_pending;
  logic [1:0]     periodic_prio;
  logic           irq;
  logic [15:0]    cs_len;
  logic [15:0]    we_pos;
  int             failures = 0;
  int             total_checks = 0;
  int             seed = 26;
  logic [31:0]    q;
  logic           e;
  logic [2:0]     modes [6] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h7, 3'h2};
  int             cdiv [6] = '{8, 8, 2, 4, 6, 1};
  int             pdiv [6] = '{8, 1, 2, 4, 6, 1};

  always #2 pclk = ~pclk;
  // Slow clock pin, phase unrelated to pclk, 20 pclk per period
  initial
  begin
    #17;
    forever #40 clk32_pin = ~clk32_pin;
  end

  csc_clock_select dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk32_pin(clk32_pin), .wdt_expire(wdt_expire), .periodic_ack(periodic_ack),
    .mem_req(mem_req), .mem_busy(mem_busy), .mem_done(mem_done), .mem_pins(mem_pins),
    .cpu_clk_tick(cpu_clk_tick), .per_clk_tick(per_clk_tick), .osc_enable(osc_enable),
    .periodic_pending(periodic_pending), .periodic_prio(periodic_prio), .irq(irq));
  csc_mem_model mem (.pclk(pclk), .presetn(presetn), .pins(mem_pins), .cs_len(cs_len), .we_pos(we_pos));

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      failures++;
      close_out();
    end
    q = prdata;
    e = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(1);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input string msg);
    apb(1'b0, a, 32'h0);
    `CHK(q, x, msg)
  endtask

  task automatic pulse_wdt();
    @(posedge pclk);
    wdt_expire <= 1'b1;
    @(posedge pclk);
    wdt_expire <= 1'b0;
    cyc(2);
  endtask

  task automatic ack();
    @(posedge pclk);
    periodic_ack <= 1'b1;
    @(posedge pclk);
    periodic_ack <= 1'b0;
    cyc(1);
  endtask

  // Dividers all divide 24, so a 24-cycle window holds exactly 24/div ticks
  task automatic ticks(input int dc, input int dp);
    int c;
    int p;
    c = 0;
    p = 0;
    repeat (24)
    begin
      @(posedge pclk);
      c += (cpu_clk_tick === 1'b1);
      p += (per_clk_tick === 1'b1);
    end
    `CHK(c, 24 / dc, "cpu ticks")
    `CHK(p, 24 / dp, "peripheral ticks")
  endtask

  function automatic int bus_len(input int unit, input logic [3:0] ws);
    return unit * (1 + ws) + ((unit > 4) ? unit : 4) + 1;
  endfunction

  task automatic mem_op(input logic w, input logic [3:0] ws, input int unit, input logic slow, input logic shrt);
    int n;
    @(posedge pclk);
    mem_req <= '{start: 1'b1, write: w, waits: ws};
    @(posedge pclk);
    mem_req.start <= 1'b0;
    for (n = 1; n < 4000; n++)
    begin
      @(posedge pclk);
      if (n == 1)
        `CHK(mem_busy, 1'b1, "bus busy")
      if (mem_done === 1'b1)
        break;
    end
    if (n == 4000)
    begin
      failures++;
      close_out();
    end
    cyc(2);
    if (!slow)
      `CHK(n, bus_len(unit, ws), "bus cycle length")
    if (slow)
      `CHK(cs_len, w ? 16'h28 : 16'h14, "slow select width")
    else if (!shrt)
      `CHK(cs_len, 16'(bus_len(unit, ws) - 1), "full select width")
    else
      `CHK(cs_len, w ? 16'h4 : 16'h2, "short select width")
    if (shrt && w)
      `CHK(we_pos, slow ? 16'h14 : 16'h2, "write release point")
  endtask

  initial
  begin
    logic [3:0] ws;
    repeat (6) @(posedge pclk);
    `CHK(mem_pins, 3'h7, "pins idle in reset")
    `CHK(osc_enable, 1'b1, "oscillator on in reset")
    presetn <= 1'b1;
    rdchk(PSC, 32'h0, "power-save reset");
    rdchk(IMK, 32'h0, "mask reset");
    pulse_wdt();
    rdchk(GCS, 32'hC0, "cause after reset");
    rdchk(GCS, 32'h0, "cause cleared");
    pulse_wdt();
    rdchk(GCS, 32'h40, "cause after watchdog");
    rdchk(GCS, 32'h0, "cause cleared");
    wr(GCS, 32'hC0);
    rdchk(GCS, 32'h0, "cause ignores writes");
    $display("test cause finished");
    for (int p = 0; p < 4; p++)
    begin
      wr(GCS, 32'(p));
      `CHK(periodic_prio, 2'(p), "priority")
    end
    cyc(400);
    `CHK(periodic_pending, 1'b1, "periodic timer request")
    wr(GCS, 32'h0);
    ack();
    cyc(400);
    `CHK(periodic_pending, 1'b0, "periodic disabled")
    wr(GCS, 32'h21);
    `CHK(periodic_pending, 1'b1, "forced pending")
    rdchk(GCS, 32'h01, "force bit reads zero");
    wr(GCS, 32'h0);
    ack();
    `CHK(periodic_pending, 1'b0, "acknowledged")
    $display("test periodic finished");
    apb(1'b0, IST, 32'h0);
    wr(IMK, 32'h1);
    pulse_wdt();
    `CHK(irq, 1'b1, "unmasked irq")
    rdchk(IST, 32'h1, "watchdog status");
    cyc(1);
    `CHK(irq, 1'b0, "irq cleared by read")
    wr(IMK, 32'h0);
    pulse_wdt();
    `CHK(irq, 1'b0, "masked irq")
    rdchk(IST, 32'h1, "masked status");
    apb(1'b0, 12'h010, 32'h0);
    `CHK({e, q}, 33'h100000000, "unmapped read")
    $display("test interrupt finished");
    wr(PSC, 32'h7);
    for (int i = 0; i < 6; i++)
    begin
      wr(GCS, {27'h0, modes[i], 2'h0});
      cyc(30);
      ticks(cdiv[i], pdiv[i]);
      ws = 4'({$random(seed)} % 4);
      mem_op(1'b0, ws, cdiv[i], 1'b0, modes[i] != 3'h2);
      ws = (i == 0) ? 4'hF : 4'({$random(seed)} % 4);
      mem_op(1'b1, ws, cdiv[i], 1'b0, modes[i] != 3'h2);
    end
    wr(GCS, 32'h0);
    wr(PSC, 32'h0);
    cyc(30);
    mem_op(1'b0, 4'h1, 8, 1'b0, 1'b0);
    $display("test fast bus finished");
    wr(PSC, 32'h7);
    wr(GCS, 32'h10);
    cyc(200);
    mem_op(1'b0, 4'h1, 1, 1'b1, 1'b1);
    mem_op(1'b1, 4'h1, 1, 1'b1, 1'b1);
    wr(PSC, 32'h17);
    wr(GCS, 32'h14);
    cyc(200);
    `CHK(osc_enable, 1'b0, "oscillator off")
    mem_op(1'b0, 4'h0, 1, 1'b1, 1'b1);
    wr(GCS, 32'h0);
    cyc(200);
    `CHK(osc_enable, 1'b1, "oscillator back on")
    $display("test slow bus finished");
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rdchk(GCS, 32'hC0, "cause after second reset");
    $display("test second reset finished");
    close_out();
  end
endmodule // tb_top

// ===== design/csc_clock_select.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
// Function
// - Cause field reads 00 idle, 01 after watchdog expiry, 11 after reset.
// - Cause field never shows the value 10.
// - Reading the global register clears the cause field; writes never change it.
// - Writing one to bit 5 forces periodic interrupt pending; bit reads zero.
// - Periodic field 00 disables, 01..11 select priority levels one to three.
// - Clock select field picks CPU/peripheral divisors; 101 stops the oscillator.
// - Short chip selects only in reduced modes; never in full-speed mode.
// - Two-bit field in power-save register enables short write chip selects.
// - Short read select in divided modes lasts final two fast cycles.
// - Short read select in 32 kHz modes lasts final 32 kHz cycle.
// - Short write select spans four fast cycles, two each side of write trailing edge.
// - Short write select spans two 32 kHz cycles, one each side of write trailing edge.
// - Wait states sit between bus phases, leaving short select length unchanged.
module csc_clock_select #(
  parameter int unsigned WAIT_W = 4
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire csc_pkg::csc_apb_req_t  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   clk32_pin,
  input  wire logic                   wdt_expire,
  input  wire logic                   periodic_ack,
  input  wire csc_pkg::csc_mem_req_t  mem_req,
  output logic                        mem_busy,
  output logic                        mem_done,
  output csc_pkg::csc_mem_pins_t      mem_pins,
  output logic                        cpu_clk_tick,
  output logic                        per_clk_tick,
  output logic                        osc_enable,
  output logic                        periodic_pending,
  output logic [1:0]                  periodic_prio,
  output logic                        irq
);
  import csc_pkg::*;

  if (WAIT_W != 4) begin : g_bad_wait_w
    $error("WAIT_W must match the mem_req waits field width of 4");
  end

  csc_state_t st;
  csc_state_t next_st;

  function automatic logic [3:0] div_of(input logic [2:0] sel, input logic cpu);
    case (sel)
      CLK_OSC8_OSC8: div_of = 4'h8;
      CLK_OSC8_OSC:  div_of = cpu ? 4'h8 : 4'h1;
      CLK_OSC2:      div_of = 4'h2;
      CLK_OSC4:      div_of = 4'h4;
      CLK_OSC6:      div_of = 4'h6;
      default:       div_of = 4'h1;
    endcase
  endfunction

  logic       edge32;
  logic       slow_act;
  logic [4:0] slow_div;
  logic       adv_clk;
  logic       adv_bus;
  logic [4:0] len2;
  logic [4:0] win;
  logic       xfer_go;
  logic       xfer_end;
  logic [2:0] irq_ev;
  logic [2:0] divsel;

  always_comb
  begin
    next_st = st;
    next_st.s32 = {st.s32[1:0], clk32_pin};
    edge32 = st.s32[1] & ~st.s32[2];
    slow_act = (st.act_sel == CLK_SLOW_ON) || (st.act_sel == CLK_SLOW_OFF);
    divsel = (st.psc[PSC_SLOWDIV_LSB +: 3] > SLOWDIV_MAX) ? SLOWDIV_MAX : st.psc[PSC_SLOWDIV_LSB +: 3];
    slow_div = 5'h01 << divsel;

    // Clock dividers; switch only when both counters wrap together
    adv_clk = slow_act ? (edge32 && ({1'b0, st.slow_cnt} == slow_div - 5'h01)) : 1'b1;
    if (edge32)
    begin
      next_st.slow_cnt = ({1'b0, st.slow_cnt} == slow_div - 5'h01) ? 4'h0 : st.slow_cnt + 4'h1;
    end
    next_st.cpu_tick = adv_clk && (st.cpu_cnt == 4'h0);
    next_st.per_tick = adv_clk && (st.perclk_cnt == 4'h0);
    if (adv_clk)
    begin
      if ((st.cpu_cnt == 4'h0) && (st.perclk_cnt == 4'h0))
      begin
        next_st.act_sel = st.clksel;
        next_st.cpu_cnt = div_of(st.clksel, 1'b1) - 4'h1;
        next_st.perclk_cnt = div_of(st.clksel, 1'b0) - 4'h1;
      end
      else
      begin
        next_st.cpu_cnt = (st.cpu_cnt == 4'h0) ? div_of(st.act_sel, 1'b1) - 4'h1 : st.cpu_cnt - 4'h1;
        next_st.perclk_cnt = (st.perclk_cnt == 4'h0) ? div_of(st.act_sel, 1'b0) - 4'h1 : st.perclk_cnt - 4'h1;
      end
    end
    next_st.osc_en = (next_st.act_sel != CLK_SLOW_OFF);

    // Memory bus cycle
    next_st.done = 1'b0;
    adv_bus = st.slow ? edge32 : 1'b1;
    len2 = st.slow ? ((st.unit_len < SECOND_MIN_SLOW) ? SECOND_MIN_SLOW : st.unit_len)
                   : ((st.unit_len < SECOND_MIN_FAST) ? SECOND_MIN_FAST : st.unit_len);
    case (st.bst)
      BUS_IDLE:
      begin
        if (mem_req.start)
        begin
          next_st.bst = BUS_FIRST;
          next_st.wr = mem_req.write;
          next_st.wleft = mem_req.waits;
          next_st.slow = slow_act;
          next_st.unit_len = slow_act ? slow_div : {1'b0, div_of(st.act_sel, 1'b1)};
          next_st.rem = next_st.unit_len;
          next_st.short_rd = st.psc[PSC_RD_SHORT_BIT] && (st.act_sel != CLK_FULL);
          next_st.short_wr = (st.psc[PSC_WR_SHORT_LSB +: 2] != 2'h0) && (st.act_sel != CLK_FULL);
        end
      end
      BUS_FIRST:
      begin
        if (adv_bus)
        begin
          if (st.rem == 5'h01)
          begin
            next_st.bst = (st.wleft != 4'h0) ? BUS_WAIT : BUS_SECOND;
            next_st.rem = (st.wleft != 4'h0) ? st.unit_len : len2;
          end
          else
          begin
            next_st.rem = st.rem - 5'h01;
          end
        end
      end
      BUS_WAIT:
      begin
        if (adv_bus)
        begin
          if (st.rem == 5'h01)
          begin
            next_st.wleft = st.wleft - 4'h1;
            next_st.bst = (st.wleft == 4'h1) ? BUS_SECOND : BUS_WAIT;
            next_st.rem = (st.wleft == 4'h1) ? len2 : st.unit_len;
          end
          else
          begin
            next_st.rem = st.rem - 5'h01;
          end
        end
      end
      BUS_SECOND:
      begin
        if (adv_bus)
        begin
          if (st.rem == 5'h01)
          begin
            next_st.bst = BUS_IDLE;
            next_st.done = 1'b1;
          end
          else
          begin
            next_st.rem = st.rem - 5'h01;
          end
        end
      end
      default:
      begin
        next_st.bst = BUS_IDLE;
      end
    endcase
    next_st.busy = (next_st.bst != BUS_IDLE);
    win = next_st.slow ? SHORT_SLOW_CYC : SHORT_FAST_CYC;
    next_st.pins.oe_n = !(next_st.busy && !next_st.wr);
    next_st.pins.we_n = !(next_st.busy && next_st.wr && !((next_st.bst == BUS_SECOND) && (next_st.rem <= win)));
    if (!next_st.busy)
    begin
      next_st.pins.cs_n = 1'b1;
    end
    else if (next_st.wr ? next_st.short_wr : next_st.short_rd)
    begin
      // Select only near the end of the second phase
      next_st.pins.cs_n = !((next_st.bst == BUS_SECOND) &&
                            (next_st.rem <= (next_st.wr ? {win[3:0], 1'b0} : win)));
    end
    else
    begin
      next_st.pins.cs_n = 1'b0;
    end

    // Periodic interrupt timer on the 32 kHz clock
    irq_ev = 3'h0;
    if (edge32 && (st.prio != 2'h0))
    begin
      next_st.per_cnt = st.per_cnt + 4'h1;
      if (st.per_cnt == PERIODIC_DIV_M1)
      begin
        irq_ev[IRQ_PERIODIC] = 1'b1;
      end
    end
    if (periodic_ack)
    begin
      next_st.per_pend = 1'b0;
    end

    // APB slave: one wait cycle, data captured at the wait edge
    xfer_go = apb_req.psel && apb_req.penable && !st.pready;
    xfer_end = apb_req.psel && apb_req.penable && st.pready;
    next_st.pready = xfer_go;
    if (xfer_go)
    begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
      if (apb_req.paddr == OFS_GLOBAL_CTRL_STATUS)
      begin
        next_st.prdata[7:0] = {st.cause, 1'b0, st.clksel, st.prio};
      end
      else if (apb_req.paddr == OFS_PSAVE_CS_CTRL)
      begin
        next_st.prdata[6:0] = st.psc;
      end
      else if (apb_req.paddr == OFS_IRQ_STATUS)
      begin
        next_st.prdata[2:0] = st.ist;
      end
      else if (apb_req.paddr == OFS_IRQ_MASK)
      begin
        next_st.prdata[2:0] = st.imask;
      end
      else
      begin
        next_st.pslverr = 1'b1;
      end
    end
    if (xfer_end && !st.pslverr)
    begin
      if (apb_req.pwrite)
      begin
        if (apb_req.paddr == OFS_GLOBAL_CTRL_STATUS)
        begin
          next_st.clksel = apb_req.pwdata[GCS_CLKSEL_LSB +: 3];
          next_st.prio = apb_req.pwdata[GCS_PRIO_LSB +: 2];
          if (apb_req.pwdata[GCS_FORCE_BIT])
          begin
            irq_ev[IRQ_PERIODIC] = 1'b1;
          end
        end
        else if (apb_req.paddr == OFS_PSAVE_CS_CTRL)
        begin
          next_st.psc = apb_req.pwdata[6:0];
        end
        else if (apb_req.paddr == OFS_IRQ_MASK)
        begin
          next_st.imask = apb_req.pwdata[2:0];
        end
      end
      else if (apb_req.paddr == OFS_GLOBAL_CTRL_STATUS)
      begin
        // Clear only what was returned
        if (st.cause == st.prdata[GCS_CAUSE_LSB +: 2])
        begin
          next_st.cause = CAUSE_NONE;
        end
      end
      else if (apb_req.paddr == OFS_IRQ_STATUS)
      begin
        next_st.ist = st.ist & ~st.prdata[2:0];
      end
    end
    irq_ev[IRQ_WDT] = wdt_expire;
    irq_ev[IRQ_BUSDONE] = next_st.done;
    if (wdt_expire && (next_st.cause != CAUSE_RESET))
    begin
      next_st.cause = CAUSE_WATCHDOG;
    end
    if (irq_ev[IRQ_PERIODIC])
    begin
      next_st.per_pend = 1'b1;
    end
    next_st.ist = next_st.ist | irq_ev;
    next_st.irq = |(next_st.ist & next_st.imask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.cause <= CAUSE_RESET;
      st.clksel <= RST_CLKSEL;
      st.act_sel <= RST_CLKSEL;
      st.prio <= RST_PRIO;
      st.psc <= RST_PSC;
      st.osc_en <= 1'b1;
      st.bst <= BUS_IDLE;
      st.pins <= 3'h7;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign mem_busy = st.busy;
  assign mem_done = st.done;
  assign mem_pins = st.pins;
  assign cpu_clk_tick = st.cpu_tick;
  assign per_clk_tick = st.per_tick;
  assign osc_enable = st.osc_en;
  assign periodic_pending = st.per_pend;
  assign periodic_prio = st.prio;
  assign irq = st.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_gcs_end;
  logic short_fast_rd;
  logic short_fast_wr;
  assign rd_gcs_end = xfer_end && !apb_req.pwrite && (apb_req.paddr == OFS_GLOBAL_CTRL_STATUS) && !st.pslverr
                      && (st.cause == st.prdata[GCS_CAUSE_LSB +: 2]);
  assign short_fast_rd = st.busy && !st.slow && !st.wr && st.short_rd;
  assign short_fast_wr = st.busy && !st.slow && st.wr && st.short_wr;

  sequence s_two_then_off;
    !st.pins.cs_n [*2] ##1 st.pins.cs_n;
  endsequence

  cause_legal_a: assert property (st.cause != 2'h2)
    else $error("cause field shows 10");
  wdt_cause_a: assert property (wdt_expire && st.cause != CAUSE_RESET |=> st.cause == CAUSE_WATCHDOG)
    else $error("watchdog expiry not reported");
  read_clear_a: assert property (rd_gcs_end && !wdt_expire |=> st.cause == CAUSE_NONE)
    else $error("cause not cleared by read");
  force_pend_a: assert property (xfer_go && !apb_req.pwrite && apb_req.paddr == OFS_GLOBAL_CTRL_STATUS
                                 |=> st.prdata[GCS_FORCE_BIT] == 1'b0)
    else $error("force bit read back as one");
  force_sets_a: assert property (xfer_end && apb_req.pwrite && apb_req.paddr == OFS_GLOBAL_CTRL_STATUS
                                 && apb_req.pwdata[GCS_FORCE_BIT] && !st.pslverr |=> st.per_pend)
    else $error("forced periodic interrupt not pending");
  prio_off_a: assert property (st.prio == 2'h0 && !xfer_end && !st.per_pend |=> !st.per_pend)
    else $error("periodic pending while disabled");
  osc_off_a: assert property (st.act_sel == CLK_SLOW_OFF |-> !st.osc_en)
    else $error("oscillator still enabled in mode 101");
  full_cs_a: assert property ($rose(st.busy) && $past(st.act_sel) == CLK_FULL |-> !st.pins.cs_n)
    else $error("chip select shortened at full speed");
  rd_fast_a: assert property ($fell(st.pins.cs_n) && short_fast_rd |-> s_two_then_off)
    else $error("short read select not two cycles");
  rd_slow_a: assert property (!st.pins.cs_n && st.slow && st.short_rd && !st.wr |-> st.rem == 5'h01)
    else $error("slow short read select too long");
  wr_fast_a: assert property ($rose(st.pins.we_n) && short_fast_wr |-> s_two_then_off)
    else $error("short write select not two cycles after edge");
  wr_slow_a: assert property (!st.pins.cs_n && st.slow && st.short_wr && st.wr |-> st.rem <= 5'h02)
    else $error("slow short write select too long");
  wait_nocs_a: assert property (st.bst == BUS_WAIT && (st.wr ? st.short_wr : st.short_rd) |-> st.pins.cs_n)
    else $error("short select active during wait states");
  sel_switch_a: assert property ($changed(st.act_sel) |-> $past({st.cpu_cnt, st.perclk_cnt}) == 8'h00)
    else $error("clock select switched mid period");
  irq_level_a: assert property (|(st.ist & st.imask) |=> st.irq || $past(xfer_end))
    else $error("interrupt output missing");

endmodule // csc_clock_select

// ===== shared/csc_pkg.sv
package csc_pkg;

  localparam int unsigned APB_AW = 12;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_GLOBAL_CTRL_STATUS = 12'h000;
  localparam logic [11:0] OFS_PSAVE_CS_CTRL      = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS         = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK           = 12'h00C;

  // Global control/status fields
  localparam int unsigned GCS_CAUSE_LSB  = 6;
  localparam int unsigned GCS_FORCE_BIT  = 5;
  localparam int unsigned GCS_CLKSEL_LSB = 2;
  localparam int unsigned GCS_PRIO_LSB   = 0;

  localparam logic [1:0] CAUSE_NONE     = 2'h0;
  localparam logic [1:0] CAUSE_WATCHDOG = 2'h1;
  localparam logic [1:0] CAUSE_RESET    = 2'h3;

  // Power-save chip-select control fields
  localparam int unsigned PSC_WR_SHORT_LSB = 0;
  localparam int unsigned PSC_RD_SHORT_BIT = 2;
  localparam int unsigned PSC_SELF_TIMED   = 3;
  localparam int unsigned PSC_SLOWDIV_LSB  = 4;
  localparam logic [2:0]  SLOWDIV_MAX      = 3'h4;

  // Clock select encodings
  localparam logic [2:0] CLK_OSC8_OSC8 = 3'h0;
  localparam logic [2:0] CLK_OSC8_OSC  = 3'h1;
  localparam logic [2:0] CLK_FULL      = 3'h2;
  localparam logic [2:0] CLK_OSC2      = 3'h3;
  localparam logic [2:0] CLK_SLOW_ON   = 3'h4;
  localparam logic [2:0] CLK_SLOW_OFF  = 3'h5;
  localparam logic [2:0] CLK_OSC4      = 3'h6;
  localparam logic [2:0] CLK_OSC6      = 3'h7;

  // Reset values
  localparam logic [2:0] RST_CLKSEL = CLK_OSC8_OSC8;
  localparam logic [1:0] RST_PRIO   = 2'h0;
  localparam logic [6:0] RST_PSC    = 7'h00;

  // Interrupt status bits
  localparam int unsigned IRQ_WDT      = 0;
  localparam int unsigned IRQ_PERIODIC = 1;
  localparam int unsigned IRQ_BUSDONE  = 2;

  // Timing counts
  localparam logic [4:0] SHORT_FAST_CYC   = 5'h02;
  localparam logic [4:0] SHORT_SLOW_CYC   = 5'h01;
  localparam logic [4:0] SECOND_MIN_FAST  = 5'h04;
  localparam logic [4:0] SECOND_MIN_SLOW  = 5'h02;
  localparam logic [3:0] PERIODIC_DIV_M1  = 4'hF;

  typedef enum logic [3:0] {
    BUS_IDLE   = 4'h1,
    BUS_FIRST  = 4'h2,
    BUS_WAIT   = 4'h4,
    BUS_SECOND = 4'h8
  } csc_bus_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
  } csc_apb_req_t;

  typedef struct packed {
    logic              start;
    logic              write;
    logic [3:0]        waits;
  } csc_mem_req_t;

  typedef struct packed {
    logic              cs_n;
    logic              we_n;
    logic              oe_n;
  } csc_mem_pins_t;

  typedef struct packed {
    logic [1:0]        cause;
    logic [2:0]        clksel;
    logic [1:0]        prio;
    logic [6:0]        psc;
    logic [2:0]        ist;
    logic [2:0]        imask;
    logic              per_pend;
    logic [3:0]        per_cnt;
    logic [2:0]        act_sel;
    logic [3:0]        cpu_cnt;
    logic [3:0]        perclk_cnt;
    logic              cpu_tick;
    logic              per_tick;
    logic              osc_en;
    logic [3:0]        slow_cnt;
    logic [2:0]        s32;
    csc_bus_t          bst;
    logic [4:0]        rem;
    logic [4:0]        unit_len;
    logic [3:0]        wleft;
    logic              wr;
    logic              short_rd;
    logic              short_wr;
    logic              slow;
    logic              busy;
    logic              done;
    csc_mem_pins_t     pins;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
  } csc_state_t;

endpackage
